// *** design/ilk_lane_reset_core.sv ***
// Transmit PCS lane logic, reset ports and receive lane mapping.
//
// Functional notes
// - Lane reset clears all transmit PCS registers but not MAC FIFO pointers.
// - No internal reset controller; only two separate domain resets exist.
// - Common receive clock output is held constantly low.
// - Receive lane clock groups are 4 bits, or 5 for 10/20 lanes.
// - Data group 0 holds lane 15 at [99:80] and lane 19 at [19:0].
`timescale 1ns/1ps
module ilk_lane_reset_core
  import ilk_reset_pkg::*;
(
  input  wire logic                      i_clock,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_mac_rst_n,
  input  wire logic                      i_tx_valid,
  input  wire logic [FIFO_WORD_BITS-1:0] i_tx_data,
  input  wire logic                      i_fifo_overflow,
  input  wire logic [GROUP_BITS-1:0]     i_receive_data_group [GROUP_COUNT],
  input  wire logic [CLK_GROUP_WIDE-1:0] i_receive_lane_clock_group
                                             [GROUP_COUNT],
  output logic                           o_tx_ready,
  output logic [FIFO_WORD_BITS-1:0]      o_lane_data,
  output logic                           o_lane_valid,
  output logic                           o_overflow,
  output logic [LANE_BITS-1:0]           o_rx_lane [TOTAL_LANES],
  output logic                           o_common_rx_clock
);

  // ****************************************************************
  // Transmit FIFO in the MAC domain
  // ****************************************************************
  // The lane clock stands in for the external transmit lane clock;
  // resets arrive already synchronised by the outside logic.
  tx_fifo_if fifo ();

  tx_mac_fifo u_fifo (
    .i_clock     (i_clock),
    .i_mac_rst_n (i_mac_rst_n),
    .fifo        (fifo)
  );

  // ****************************************************************
  // Transmit PCS registers
  // ****************************************************************
  logic                      overflow_q;
  logic                      wr_en_q;
  logic [FIFO_WORD_BITS-1:0] wr_data_q;
  logic [FIFO_WORD_BITS-1:0] lane_data_q;
  logic                      lane_valid_q;

  // Overflow is sticky; the lane reset is the only way to clear it.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      overflow_q <= 1'b0;
    end else if (i_fifo_overflow) begin
      overflow_q <= 1'b1;
    end
  end

  // Write enable is held low during lane reset so no new words land.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_en_q <= 1'b0;
    end else begin
      wr_en_q <= i_tx_valid && !overflow_q;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_data_q <= WORD_RESET;
    end else begin
      wr_data_q <= i_tx_data;
    end
  end

  assign fifo.wr_en   = wr_en_q;
  assign fifo.wr_data = wr_data_q;
  assign o_tx_ready   = !overflow_q;
  assign o_overflow   = overflow_q;

  // Read side keeps running under lane reset so the FIFO drains.
  assign fifo.rd_en = fifo.rd_valid;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lane_data_q <= WORD_RESET;
    end else begin
      lane_data_q <= fifo.rd_data;
    end
  end

  // Words read while the lane reset is low are dropped on purpose.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lane_valid_q <= 1'b0;
    end else begin
      lane_valid_q <= fifo.rd_valid;
    end
  end

  assign o_lane_data  = lane_data_q;
  assign o_lane_valid = lane_valid_q;

  // ****************************************************************
  // Receive lane mapping
  // ****************************************************************
  // Receive words arrive on the outside transceivers' lane clocks, so
  // each lane passes two flops before it is shown. The lane reset
  // belongs to the transmit side and leaves this path running.
  // Lane 0 sits in the top bits of the highest group.
  for (genvar l = 0; l < TOTAL_LANES; l++) begin : g_rx_lane
    localparam int GRP = GROUP_COUNT - 1 - (l / GROUP_LANES);
    localparam int POS = GROUP_LANES - 1 - (l % GROUP_LANES);
    logic [LANE_BITS-1:0] capture_q;
    logic [LANE_BITS-1:0] settle_q;

    always_ff @(posedge i_clock) begin
      capture_q <= i_receive_data_group[GRP][POS*LANE_BITS +: LANE_BITS];
    end

    always_ff @(posedge i_clock) begin
      settle_q <= capture_q;
    end

    assign o_rx_lane[l] = settle_q;
  end

  // Lane clocks are forwarded by the outside transceivers; with the
  // widest build every group is CLK_GROUP_WIDE bits.

  // ****************************************************************
  // Fixed outputs
  // ****************************************************************
  // No reset controller lives here; only the separate resets.
  assign o_common_rx_clock = COMMON_RX_CLOCK_LEVEL;

endmodule

// *** design/ilk_reset_pkg.sv ***
// Package with shared constants for the transmit lane reset block.
package ilk_reset_pkg;

  // ****************************************************************
  // Lane geometry
  // ****************************************************************
  localparam int LANE_BITS        = 20;
  localparam int GROUP_LANES      = 5;
  localparam int GROUP_COUNT      = 4;
  localparam int GROUP_BITS       = LANE_BITS * GROUP_LANES;
  localparam int TOTAL_LANES      = GROUP_LANES * GROUP_COUNT;
  localparam int CLK_GROUP_NARROW = 4;
  localparam int CLK_GROUP_WIDE   = 5;

  // ****************************************************************
  // Transmit FIFO
  // ****************************************************************
  localparam int FIFO_DEPTH      = 256;
  localparam int FIFO_PTR_BITS   = 8;
  localparam int FIFO_WORD_BITS  = 64;
  localparam logic [FIFO_PTR_BITS-1:0] PTR_RESET = 8'h00;
  localparam logic [FIFO_WORD_BITS-1:0] WORD_RESET = 64'h0;

  localparam logic COMMON_RX_CLOCK_LEVEL = 1'b0;

endpackage

// *** design/tx_fifo_if.sv ***
// Interface carrying transmit FIFO write and read sides between MAC and lane logic.
`timescale 1ns/1ps
interface tx_fifo_if;
  import ilk_reset_pkg::*;
  logic                      wr_en;
  logic [FIFO_WORD_BITS-1:0] wr_data;
  logic                      rd_valid;
  logic [FIFO_WORD_BITS-1:0] rd_data;
  logic                      rd_en;
  modport mac  (input wr_en, input wr_data, output rd_valid,
                output rd_data, input rd_en);
  modport lane (output wr_en, output wr_data, input rd_valid,
                input rd_data, output rd_en);
endinterface

// *** design/tx_mac_fifo.sv ***
// Transmit MAC FIFO whose pointers are reset only by the MAC reset.
`timescale 1ns/1ps
module tx_mac_fifo
  import ilk_reset_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_mac_rst_n,
  tx_fifo_if.mac    fifo
);

  logic [FIFO_WORD_BITS-1:0] mem_q [FIFO_DEPTH];
  logic [FIFO_PTR_BITS:0]    wr_ptr_q;
  logic [FIFO_PTR_BITS:0]    rd_ptr_q;
  logic                      full;
  logic                      empty;

  assign empty = (wr_ptr_q == rd_ptr_q);
  assign full  = (wr_ptr_q[FIFO_PTR_BITS] != rd_ptr_q[FIFO_PTR_BITS]) &&
                 (wr_ptr_q[FIFO_PTR_BITS-1:0] == rd_ptr_q[FIFO_PTR_BITS-1:0]);
  assign fifo.rd_valid = !empty;
  assign fifo.rd_data  = mem_q[rd_ptr_q[FIFO_PTR_BITS-1:0]];

  // Pointers answer to the MAC reset alone, so a lane reset drains.
  always_ff @(posedge i_clock or negedge i_mac_rst_n) begin
    if (!i_mac_rst_n) begin
      wr_ptr_q <= {1'b0, PTR_RESET};
    end else if (fifo.wr_en && !full) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_mac_rst_n) begin
    if (!i_mac_rst_n) begin
      rd_ptr_q <= {1'b0, PTR_RESET};
    end else if (fifo.rd_en && !empty) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  // Storage carries no reset; stale words are never readable.
  always_ff @(posedge i_clock) begin
    if (fifo.wr_en && !full) begin
      mem_q[wr_ptr_q[FIFO_PTR_BITS-1:0]] <= fifo.wr_data;
    end
  end

endmodule

// *** test/ilk_reset_driver.sv ***
// Model of the user logic that sequences the two core resets.
`timescale 1ns/1ps
module ilk_reset_driver (
  input  wire logic i_clock,
  input  wire logic i_start,
  output logic      o_lane_rst_n,
  output logic      o_mac_rst_n
);
  logic [9:0] count_q;
  logic [1:0] lane_q;
  logic [1:0] mac_q;
  // Start drops all resets at once; each release crosses two flops.
  // The order is made here; a tool-made global reset would break it.
  always_ff @(posedge i_clock or posedge i_start) begin
    if (i_start) begin
      count_q <= 10'h000;
      lane_q  <= 2'h0;
      mac_q   <= 2'h0;
    end else begin
      if (count_q != 10'h3FF) count_q <= count_q + 10'h001;
      lane_q <= {lane_q[0], count_q >= 10'h100};
      mac_q  <= {mac_q[0], count_q >= 10'h202};
    end
  end
  assign o_lane_rst_n = lane_q[1];
  assign o_mac_rst_n  = mac_q[1];
endmodule

// *** test/ilk_reset_checker.sv ***
// Port assertions for the lane reset core.
`timescale 1ns/1ps
module ilk_reset_checker
  import ilk_reset_pkg::*;
(
  input wire logic                  i_clock,
  input wire logic                  i_rst_n,
  input wire logic                  i_fifo_overflow,
  input wire logic [GROUP_BITS-1:0] i_receive_data_group [GROUP_COUNT],
  input wire logic                  o_tx_ready,
  input wire logic                  o_lane_valid,
  input wire logic                  o_overflow,
  input wire logic [LANE_BITS-1:0]  o_rx_lane [TOTAL_LANES],
  input wire logic                  o_common_rx_clock
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence s_raise; i_fifo_overflow; endsequence
  sequence s_kept; o_overflow [*2]; endsequence
  a_rx_clock_low: assert property (o_common_rx_clock == 1'b0)
    else $error("common clock high");
  a_lane15_map: assert property (
    o_rx_lane[15] == $past(i_receive_data_group[0][99:80], 2))
    else $error("lane 15 map");
  a_lane19_map: assert property (
    o_rx_lane[19] == $past(i_receive_data_group[0][19:0], 2))
    else $error("lane 19 map");
  a_reset_clears: assert property (
    disable iff (1'b0) !i_rst_n |-> !o_overflow && !o_lane_valid)
    else $error("reset left state");
  a_flag_sticky: assert property (s_raise |=> s_kept)
    else $error("overflow lost");
  a_ready_inverse: assert property (o_tx_ready == !o_overflow)
    else $error("ready wrong");
endmodule
bind ilk_lane_reset_core ilk_reset_checker u_chk (.i_clock, .i_rst_n,
  .i_fifo_overflow, .i_receive_data_group, .o_tx_ready, .o_lane_valid,
  .o_overflow, .o_rx_lane, .o_common_rx_clock);

// *** test/ilk_lane_reset_core_test.sv ***
// Self-checking testbench for the lane reset core.
`timescale 1ns/1ps
module ilk_lane_reset_core_test;
  import ilk_reset_pkg::*;
  logic i_clock = 1'b0, i_start = 1'b0, kill_n = 1'b1, lane_n, i_mac_rst_n;
  wire logic i_rst_n = lane_n & kill_n;
  logic i_tx_valid = 1'b0, i_fifo_overflow = 1'b0;
  logic [FIFO_WORD_BITS-1:0] i_tx_data = 64'h0, o_lane_data;
  logic [GROUP_BITS-1:0]     i_receive_data_group [GROUP_COUNT];
  logic [CLK_GROUP_WIDE-1:0] i_receive_lane_clock_group [GROUP_COUNT];
  logic o_tx_ready, o_lane_valid, o_overflow, o_common_rx_clock;
  logic [LANE_BITS-1:0]      o_rx_lane [TOTAL_LANES];
  int miscompares = 0, checks_done = 0, cycles = 0;
  ilk_reset_driver i_drv (.i_clock, .i_start, .o_lane_rst_n(lane_n),
    .o_mac_rst_n(i_mac_rst_n));
  ilk_lane_reset_core i_dut (.i_clock, .i_rst_n, .i_mac_rst_n, .i_tx_valid,
    .i_tx_data, .i_fifo_overflow, .i_receive_data_group,
    .i_receive_lane_clock_group, .o_tx_ready, .o_lane_data, .o_lane_valid,
    .o_overflow, .o_rx_lane, .o_common_rx_clock);
  initial forever #4 i_clock = ~i_clock;
  // The whole run needs about 600 cycles, so 4000 means a hang.
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    checks_done++;
    if (seen !== want) begin
      miscompares++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic send(input logic [63:0] word);
    @(posedge i_clock) i_tx_valid <= 1'b1;
    i_tx_data <= word;
    @(posedge i_clock) i_tx_valid <= 1'b0;
    for (int n = 0; n < 8 && o_lane_valid !== 1'b1; n++) @(negedge i_clock);
    check(o_lane_valid, 1'b1);
    check(o_lane_data, word);
  endtask
  task automatic t_map();
    @(posedge i_clock);
    for (int g = 0; g < GROUP_COUNT; g++)
      for (int s = 0; s < GROUP_LANES; s++)
        i_receive_data_group[g][s*20+:20] <= 20'(32'hC0000 + g * 16 + s);
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    for (int l = 0; l < TOTAL_LANES; l++)
      check(o_rx_lane[l], 32'hC0000 + (3 - l / 5) * 16 + 4 - l % 5);
    check($bits(i_dut.i_receive_lane_clock_group[0]), 5);
    check(o_common_rx_clock, 1'b0);
    $display("test map done");
  endtask
  task automatic t_lane_reset();
    @(posedge i_clock) i_fifo_overflow <= 1'b1;
    @(posedge i_clock) i_fifo_overflow <= 1'b0;
    @(negedge i_clock);
    check(o_tx_ready, 1'b0);
    @(posedge i_clock) i_tx_valid <= 1'b1;
    @(posedge i_clock) i_tx_valid <= 1'b0;
    repeat (3) @(negedge i_clock) check(o_lane_valid, 1'b0);
    @(posedge i_clock) kill_n <= 1'b0;
    repeat (3) @(posedge i_clock);
    kill_n <= 1'b1;
    @(negedge i_clock);
    check(o_overflow, 1'b0);
    send(64'h0123456789ABCDEF);
    $display("test lane reset done");
  endtask
  task automatic t_reset_sequence();
    int gap;
    gap = 0;
    for (int n = 0; n < 600 && lane_n !== 1'b1; n++) @(negedge i_clock);
    while (i_mac_rst_n !== 1'b1 && gap < 600) begin
      @(negedge i_clock);
      gap++;
    end
    check(lane_n, 1'b1);
    check(i_mac_rst_n, 1'b1);
    check(gap >= 256, 1'b1);
    send(64'hFEDCBA9876543210);
    $display("test reset sequence done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    i_start <= 1'b1;
    for (int g = 0; g < GROUP_COUNT; g++) begin
      i_receive_data_group[g] = '0;
      i_receive_lane_clock_group[g] = '0;
    end
    repeat (12) @(posedge i_clock);
    i_start <= 1'b0;
    t_reset_sequence();
    t_map();
    t_lane_reset();
    complete_run();
  end
endmodule
